// >>> bench/reset_irq_flag_sampling_tb.sv
// Self-checking bench for the reset, request and flag sampling block.
// Assumes rsf_ctrl and rsf_sys_model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module reset_irq_flag_sampling_tb;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic tim = 1'b0;
    logic [3:0] irq_clear = 4'h0, drv_val = 4'h0, drv_en = 4'h0;
    logic rst_n, run, start, locked, tout;
    logic [3:0] irq_n, ext, pend, cond, f_out, f_oe, pins;
    logic [23:0] addr;
    logic [43:0] q[$];
    logic [43:0] obs;
    logic [31:0] rnd = 32'hee28_30e1;
    int n_errors = 0;
    int tests_run = 0;
    always #2 clk = ~clk;
    assign pins = (f_oe & f_out) | (~f_oe & ext);
    assign obs = {run, start, addr, locked, pend, cond, f_out, f_oe, tout};
    rsf_sys_model u_sys (.clk(clk), .reset_pin_n(rst_n), .interrupt_request_lines_n(irq_n), .flag_ext(ext));
    rsf_ctrl #(.LOCK_CYCLES(8)) u_dut (.clk(clk), .sys_rst(sys_rst), .reset_pin_n(rst_n),
        .interrupt_request_lines_n(irq_n), .irq_clear(irq_clear), .general_flag_pins_in(pins),
        .flag_drive_value(drv_val), .flag_drive_enable(drv_en), .timer_expired(tim), .core_run(run),
        .core_start(start), .fetch_address(addr), .pll_locked(locked), .irq_pending(pend),
        .flag_condition(cond), .general_flag_pins_out(f_out), .general_flag_pins_oe(f_oe),
        .timer_expired_out(tout));
    always @(negedge clk) begin
        logic [43:0] e;
        if (q.size() > 0) begin
            e = q.pop_front();
            tests_run++;
            if (obs !== e) begin
                n_errors++;
                $display("BAD %0t %h %h", $time, obs, e);
            end
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic chk(input logic r, s, input logic [23:0] a, input logic l, input logic [3:0] p);
        q.push_back({r, s, a, l, p, (drv_en & drv_val) | (~drv_en & ext), drv_val, drv_en, tim});
    endtask : chk
    task automatic test_done;
        if (n_errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done
    initial begin
        #4000;
        n_errors++;
        test_done();
    end
    initial begin
        step(16);
        sys_rst = 1'b0;
        u_sys.pin(1'b0, 5);
        u_sys.pin(1'b1, 1);
        u_sys.pin(1'b0, 5);
        chk(0, 0, 24'h00_0000, 0, 4'h0);
        u_sys.pin(1'b0, 2);
        chk(0, 0, 24'h00_0000, 0, 4'h0);
        u_sys.pin(1'b0, 1);
        chk(0, 0, 24'h00_0000, 1, 4'h0);
        u_sys.pin(1'b1, 1);
        chk(1, 1, 24'h00_0008, 1, 4'h0);
        u_sys.pin(1'b1, 1);
        chk(1, 0, 24'h00_0008, 1, 4'h0);
        u_sys.pin(1'b0, 3);
        chk(1, 0, 24'h00_0008, 1, 4'h0);
        u_sys.pin(1'b1, 1);
        chk(1, 0, 24'h00_0008, 1, 4'h0);
        u_sys.pin(1'b0, 4);
        chk(0, 0, 24'h00_0008, 1, 4'h0);
        u_sys.pin(1'b1, 1);
        chk(1, 1, 24'h00_0008, 1, 4'h0);
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            u_sys.req(~rnd[3:0], ext);
            step(1);
            chk(1, 0, 24'h00_0008, 1, rnd[3:0]);
            u_sys.req(4'hf, ext);
            step(2);
            chk(1, 0, 24'h00_0008, 1, rnd[3:0]);
            irq_clear = 4'hf;
            step(1);
            irq_clear = 4'h0;
            chk(1, 0, 24'h00_0008, 1, 4'h0);
        end
        u_sys.req(4'h0, ext);
        irq_clear = 4'hf;
        step(1);
        chk(1, 0, 24'h00_0008, 1, 4'hf);
        step(1);
        chk(1, 0, 24'h00_0008, 1, 4'hf);
        u_sys.req(4'hf, ext);
        step(1);
        irq_clear = 4'h0;
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            {tim, drv_en, drv_val} = rnd[8:0];
            u_sys.req(4'hf, rnd[12:9]);
            step(3);
            chk(1, 0, 24'h00_0008, 1, 4'h0);
        end
        step(1);
        test_done();
    end
endmodule : reset_irq_flag_sampling_tb
`default_nettype wire

// >>> bench/rsf_sys_model.sv
// Board logic model: reset pin, request lines, external flag levels.
// Assumes callers enter its tasks just after a rising clk edge.
`timescale 1ns/10ps
`default_nettype none
module rsf_sys_model (
    input wire logic clk,
    output logic reset_pin_n,
    output logic [3:0] interrupt_request_lines_n,
    output logic [3:0] flag_ext
);
    initial begin
        reset_pin_n = 1'b0;
        interrupt_request_lines_n = 4'hf;
        flag_ext = 4'h0;
    end
    // Holds a reset level for n sampling edges
    task automatic pin(input logic lvl, input int n);
        reset_pin_n = lvl;
        repeat (n) @(posedge clk);
        #1;
    endtask : pin
    task automatic req(input logic [3:0] v, input logic [3:0] f);
        interrupt_request_lines_n = v;
        flag_ext = f;
    endtask : req
endmodule : rsf_sys_model
`default_nettype wire

// >>> rtl/rsf_ctrl.sv
// Reset sequencing, interrupt request latching and flag pin sampling at the core boundary.
// Assumes the reset, interrupt and flag pins are already synchronous to clk.
`timescale 1ns/10ps
`default_nettype none

// Function
// - Power-up reset held low until 1000 clocks
// - Execution starts at address 8 after release
// - Low request sampled at edge latches pending
// - Low pulse of period plus 5 ns captured
// - Sampled input flags steer next cycle's conditions
module rsf_ctrl #(
    parameter int LOCK_CYCLES = rsf_pkg::PLL_LOCK_CYCLES,
    parameter int RESET_MIN = rsf_pkg::RESET_MIN_CYCLES,
    parameter int IRQ_N = rsf_pkg::IRQ_LINES,
    parameter int FLAG_N = rsf_pkg::FLAG_PINS,
    parameter int ADDR_W = rsf_pkg::FETCH_ADDR_BITS
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic reset_pin_n,
    input wire logic [IRQ_N-1:0] interrupt_request_lines_n,
    input wire logic [IRQ_N-1:0] irq_clear,
    input wire logic [FLAG_N-1:0] general_flag_pins_in,
    input wire logic [FLAG_N-1:0] flag_drive_value,
    input wire logic [FLAG_N-1:0] flag_drive_enable,
    input wire logic timer_expired,
    output logic core_run,
    output logic core_start,
    output logic [ADDR_W-1:0] fetch_address,
    output logic pll_locked,
    output logic [IRQ_N-1:0] irq_pending,
    output logic [FLAG_N-1:0] flag_condition,
    output logic [FLAG_N-1:0] general_flag_pins_out,
    output logic [FLAG_N-1:0] general_flag_pins_oe,
    output logic timer_expired_out
);

    localparam int CNT_W = $clog2(LOCK_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LOCK = CNT_W'(LOCK_CYCLES);
    localparam logic [CNT_W-1:0] CNT_RESET = CNT_W'(RESET_MIN);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    typedef struct packed {
        rsf_pkg::rsf_seq_type seq;
        logic [CNT_W-1:0] low_count;
        logic locked;
        logic run;
        logic start;
        logic [ADDR_W-1:0] fetch;
        logic [IRQ_N-1:0] pending;
        logic [FLAG_N-1:0] cond;
        logic [FLAG_N-1:0] flag_out;
        logic [FLAG_N-1:0] flag_oe;
        logic tmr_done;
    } rsf_state_type;

    rsf_state_type state;
    rsf_state_type next_state;
    logic [CNT_W-1:0] next_low;

    always_comb begin
        next_state = state;
        next_state.start = 1'b0;
        // Consecutive low samples of the reset pin, saturating
        if (reset_pin_n) begin
            next_low = '0;
        end else if (state.low_count == CNT_LOCK) begin
            next_low = state.low_count;
        end else begin
            next_low = state.low_count + CNT_ONE;
        end
        next_state.low_count = next_low;
        unique case (state.seq)
            rsf_pkg::RSF_POWER_UP: begin
                if (next_low == CNT_LOCK) begin
                    next_state.locked = 1'b1;
                    next_state.seq = rsf_pkg::RSF_HELD;
                end
            end
            rsf_pkg::RSF_HELD: begin
                if (reset_pin_n) begin
                    next_state.seq = rsf_pkg::RSF_RUN;
                    next_state.run = 1'b1;
                    next_state.start = 1'b1;
                    next_state.fetch = rsf_pkg::START_ADDRESS[ADDR_W-1:0];
                end
            end
            rsf_pkg::RSF_RUN: begin
                if (next_low >= CNT_RESET) begin
                    next_state.seq = rsf_pkg::RSF_HELD;
                    next_state.run = 1'b0;
                end
            end
            default: begin
                next_state.seq = rsf_pkg::RSF_POWER_UP;
                next_state.run = 1'b0;
            end
        endcase
        // A new request wins over a clear in the same cycle; a pulse of a period plus 5 ns spans an edge
        next_state.pending = (state.pending & ~irq_clear) | ~interrupt_request_lines_n;
        // Input pins give the sampled level, output pins their own driven level
        next_state.cond = (general_flag_pins_in & ~state.flag_oe) | (state.flag_out & state.flag_oe);
        next_state.flag_out = flag_drive_value;
        next_state.flag_oe = flag_drive_enable;
        next_state.tmr_done = timer_expired;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= '{seq: rsf_pkg::RSF_POWER_UP, default: '0};
        end else begin
            state <= next_state;
        end
    end

    assign core_run = state.run;
    assign core_start = state.start;
    assign fetch_address = state.fetch;
    assign pll_locked = state.locked;
    assign irq_pending = state.pending;
    assign flag_condition = state.cond;
    assign general_flag_pins_out = state.flag_out;
    assign general_flag_pins_oe = state.flag_oe;
    assign timer_expired_out = state.tmr_done;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_short_low;
        core_run && reset_pin_n ##1 !reset_pin_n [*3] ##1 reset_pin_n;
    endsequence

    sequence s_long_low;
        core_run && !reset_pin_n ##1 !reset_pin_n [*3];
    endsequence

    sequence s_irq0_pulse;
        !interrupt_request_lines_n[0] [*2];
    endsequence

    sequence s_release;
        !core_run && pll_locked && reset_pin_n;
    endsequence

    property p_short_reset;
        s_short_low |=> core_run;
    endproperty
    a_short_reset: assert property (p_short_reset) else $error("Short reset pulse stopped the core");

    property p_long_reset;
        s_long_low |=> !core_run ##0 !core_start;
    endproperty
    a_long_reset: assert property (p_long_reset) else $error("Four low clocks did not reset the core");

    property p_lock_before_start;
        core_start |-> pll_locked && $past(state.seq) == rsf_pkg::RSF_HELD;
    endproperty
    a_lock_before_start: assert property (p_lock_before_start) else $error("Core started before lock");

    property p_start_address;
        core_start |-> core_run && fetch_address == rsf_pkg::START_ADDRESS[ADDR_W-1:0] && $past(reset_pin_n);
    endproperty
    a_start_address: assert property (p_start_address) else $error("Start not at address 8");

    property p_irq_latch;
        1 |=> (irq_pending & ~$past(interrupt_request_lines_n)) == ~$past(interrupt_request_lines_n);
    endproperty
    a_irq_latch: assert property (p_irq_latch) else $error("Sampled request not pending");

    property p_irq_pulse;
        s_irq0_pulse |-> irq_pending[0];
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("Wide request pulse lost");

    property p_flag_input;
        ##1 1 |-> (flag_condition & ~$past(general_flag_pins_oe))
            == ($past(general_flag_pins_in) & ~$past(general_flag_pins_oe));
    endproperty
    a_flag_input: assert property (p_flag_input) else $error("Flag condition does not follow input pins");

    property p_flag_out;
        1 |=> general_flag_pins_out == $past(flag_drive_value) && general_flag_pins_oe == $past(flag_drive_enable)
            && timer_expired_out == $past(timer_expired);
    endproperty
    a_flag_out: assert property (p_flag_out) else $error("Flag or timer output not registered");

    property p_run_hold;
        core_run && reset_pin_n |=> core_run;
    endproperty
    a_run_hold: assert property (p_run_hold) else $error("Core stopped with reset pin high");

    property p_lock_hold;
        !pll_locked && reset_pin_n |=> !pll_locked;
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("Lock taken after a high reset sample");

    property p_lock_stays;
        pll_locked |=> pll_locked;
    endproperty
    a_lock_stays: assert property (p_lock_stays) else $error("Lock lost without system reset");

    property p_lock_low;
        $rose(pll_locked) |-> !$past(reset_pin_n);
    endproperty
    a_lock_low: assert property (p_lock_low) else $error("Lock taken without reset pin low");

    property p_no_run_unlocked;
        !pll_locked |-> !core_run && !core_start;
    endproperty
    a_no_run_unlocked: assert property (p_no_run_unlocked) else $error("Core running before lock");

    property p_start_release;
        s_release |=> core_start && core_run;
    endproperty
    a_start_release: assert property (p_start_release) else $error("Release did not start the core");

    property p_start_pulse;
        core_start |=> !core_start;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("Start pulse longer than one cycle");

    property p_irq_sticky;
        1 |=> ($past(irq_pending) & ~$past(irq_clear) & ~irq_pending) == '0;
    endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("Pending request lost without clear");

    property p_irq_clear;
        1 |=> (irq_pending & $past(irq_clear) & $past(interrupt_request_lines_n)) == '0;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("Cleared request still pending");

    property p_flag_driven;
        ##1 1 |-> (flag_condition & $past(general_flag_pins_oe))
            == ($past(general_flag_pins_out) & $past(general_flag_pins_oe));
    endproperty
    a_flag_driven: assert property (p_flag_driven) else $error("Output flag condition not driven level");

endmodule : rsf_ctrl

`default_nettype wire

// >>> rtl/rsf_pkg.sv
// Constants for the reset, interrupt request and flag sampling block.
// Assumes a single 250 MHz clock drives every register of the block.
`default_nettype none
package rsf_pkg;

    // Clock period of the sampling clock
    localparam int CLK_PERIOD_NS = 4;

    // Shortest reset low time accepted once power-up is over, in input clocks
    localparam int RESET_MIN_CYCLES = 4;

    // Input clocks that reset must stay low at power up for the clock multiplier to settle
    localparam int PLL_LOCK_CYCLES = 1000;

    // Program address where execution begins after reset
    localparam logic [31:0] START_ADDRESS = 32'h0000_0008;

    // Pin group widths
    localparam int IRQ_LINES = 4;
    localparam int FLAG_PINS = 4;
    localparam int FETCH_ADDR_BITS = 24;

    // Reset sequencer states
    typedef enum logic [1:0] {
        RSF_POWER_UP = 2'b00,
        RSF_HELD = 2'b01,
        RSF_RUN = 2'b10
    } rsf_seq_type;

endpackage : rsf_pkg
`default_nettype wire
